// ### verilog/lip_port_group.sv
// Five bidirectional ports with output latches, four with direction control.
// Assumes the processor sequencer marks internal states S1 and S2 with
// one-cycle strobes on clk_sys, and that pins are resolved outside.
//
// Overview of operation
// - Each output pin is driven from its own latch, held until rewritten.
// - Input paths keep no copy; a read returns the live pin level.
// - Pin levels are sampled in state S1 of the read cycle.
// - Written data enters the output latch in state S2 of the write cycle.
// - Read-modify-write instruction reads return the output latch contents.
// - All other reads of a port latch address return the pin level.
// - Five ports of six, three, eight, eight and eight bits, 33 pins.
// - The first port is six bits, direction chosen per pin.
// - Reset clears the first port direction register, all pins inputs.
// - Reset clears the first port output latch.
// - A direction bit of zero selects input, one selects output.
`timescale 1ns/1ns
module lip_port_group (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire lip_pkg::lip_bus_t    bus,
  output logic [7:0]                bus_rdata,
  input  wire lip_pkg::lip_pins_t   pin_in,
  output lip_pkg::lip_pins_t        pin_out,
  output lip_pkg::lip_pins_t        pin_oe
);

  // Output latches.
  logic [5:0] p1_latch_r;
  logic [2:0] p2_latch_r;
  logic [7:0] p3_latch_r;
  logic [7:0] p4_latch_r;
  logic [7:0] p6_latch_r;

  // Direction and open-drain control.
  logic [5:0] p1_dir_r;
  logic [7:0] p3_dir_r;
  logic [7:0] p4_dir_r;
  logic [7:0] p6_dir_r;
  logic [7:0] p3_ode_r;
  logic [7:0] p4_ode_r;

  // Synchronised pin levels.
  lip_pkg::lip_pins_t pin_sync;
  logic [32:0]        pin_raw;

  assign pin_raw = pin_in;

  lip_sync #(
    .W (lip_pkg::PIN_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (pin_raw),
    .q       (pin_sync)
  );

  // Address decode, one hit wire per register. The read side keeps its own
  // case so that an address of another block falls to zero there.
  wire hit_p1 = (bus.addr == lip_pkg::ADDR_P1_LATCH);
  wire hit_p2 = (bus.addr == lip_pkg::ADDR_P2_LATCH);
  wire hit_p3 = (bus.addr == lip_pkg::ADDR_P3_LATCH);
  wire hit_p4 = (bus.addr == lip_pkg::ADDR_P4_LATCH);
  wire hit_p6 = (bus.addr == lip_pkg::ADDR_P6_LATCH);
  wire hit_d1 = (bus.addr == lip_pkg::ADDR_P1_DIR);
  wire hit_d3 = (bus.addr == lip_pkg::ADDR_P3_DIR);
  wire hit_d4 = (bus.addr == lip_pkg::ADDR_P4_DIR);
  wire hit_d6 = (bus.addr == lip_pkg::ADDR_P6_DIR);
  wire hit_o3 = (bus.addr == lip_pkg::ADDR_P3_ODE);
  wire hit_o4 = (bus.addr == lip_pkg::ADDR_P4_ODE);

  // Write strobes fire only in S2 of the write cycle. Gating on S2 keeps a
  // register from loading while the address and data of the cycle settle.
  wire wr_s2 = bus.wr & bus.s2;
  wire we_p1 = wr_s2 & hit_p1;
  wire we_p2 = wr_s2 & hit_p2;
  wire we_p3 = wr_s2 & hit_p3;
  wire we_p4 = wr_s2 & hit_p4;
  wire we_p6 = wr_s2 & hit_p6;
  wire we_d1 = wr_s2 & hit_d1;
  wire we_d3 = wr_s2 & hit_d3;
  wire we_d4 = wr_s2 & hit_d4;
  wire we_d6 = wr_s2 & hit_d6;
  wire we_o3 = wr_s2 & hit_o3;
  wire we_o4 = wr_s2 & hit_o4;

  // Next latch values; a latch changes only on its own write.
  wire [5:0] p1_latch_nxt = we_p1 ? bus.wdata[5:0] : p1_latch_r;
  wire [2:0] p2_latch_nxt = we_p2 ? bus.wdata[2:0] : p2_latch_r;
  wire [7:0] p3_latch_nxt = we_p3 ? bus.wdata      : p3_latch_r;
  wire [7:0] p4_latch_nxt = we_p4 ? bus.wdata      : p4_latch_r;
  wire [7:0] p6_latch_nxt = we_p6 ? bus.wdata      : p6_latch_r;

  // Next control values.
  wire [5:0] p1_dir_nxt = we_d1 ? bus.wdata[5:0] : p1_dir_r;
  wire [7:0] p3_dir_nxt = we_d3 ? bus.wdata      : p3_dir_r;
  wire [7:0] p4_dir_nxt = we_d4 ? bus.wdata      : p4_dir_r;
  wire [7:0] p6_dir_nxt = we_d6 ? bus.wdata      : p6_dir_r;
  wire [7:0] p3_ode_nxt = we_o3 ? bus.wdata      : p3_ode_r;
  wire [7:0] p4_ode_nxt = we_o4 ? bus.wdata      : p4_ode_r;

  // First port latch; it clears so no pin shows a stale level after reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_latch_r <= lip_pkg::RST_LATCH[5:0];
    end else begin
      p1_latch_r <= p1_latch_nxt;
    end
  end

  // Second port latch; it sets to ones so that its open-drain pins float
  // high and the port can serve as input without a write first.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p2_latch_r <= lip_pkg::RST_P2_LATCH;
    end else begin
      p2_latch_r <= p2_latch_nxt;
    end
  end

  // Third port latch.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p3_latch_r <= lip_pkg::RST_LATCH;
    end else begin
      p3_latch_r <= p3_latch_nxt;
    end
  end

  // Fourth port latch.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p4_latch_r <= lip_pkg::RST_LATCH;
    end else begin
      p4_latch_r <= p4_latch_nxt;
    end
  end

  // Sixth port latch; software must clear the direction bit before using a pin as an
  // input, since the latch alone does not release a push-pull pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p6_latch_r <= lip_pkg::RST_LATCH;
    end else begin
      p6_latch_r <= p6_latch_nxt;
    end
  end

  // First port direction; zero from reset so every pin starts as an input
  // and no driver fights whatever the board puts on the pin.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1_dir_r <= lip_pkg::RST_DIR[5:0];
    end else begin
      p1_dir_r <= p1_dir_nxt;
    end
  end

  // Third port direction.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p3_dir_r <= lip_pkg::RST_DIR;
    end else begin
      p3_dir_r <= p3_dir_nxt;
    end
  end

  // Fourth port direction.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p4_dir_r <= lip_pkg::RST_DIR;
    end else begin
      p4_dir_r <= p4_dir_nxt;
    end
  end

  // Sixth port direction.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p6_dir_r <= lip_pkg::RST_DIR;
    end else begin
      p6_dir_r <= p6_dir_nxt;
    end
  end

  // Third port open-drain select; push-pull from reset. In open drain a latch
  // one releases the pin, so several devices may share one wired line.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p3_ode_r <= lip_pkg::RST_ODE;
    end else begin
      p3_ode_r <= p3_ode_nxt;
    end
  end

  // Fourth port open-drain select; push-pull from reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p4_ode_r <= lip_pkg::RST_ODE;
    end else begin
      p4_ode_r <= p4_ode_nxt;
    end
  end

  // Read source per port: latch for read-modify-write, live pin otherwise.
  // The pin value is the synchroniser output, so no extra copy is kept.
  wire [5:0] p1_rd = bus.rmw ? p1_latch_r : pin_sync.p1;
  wire [2:0] p2_rd = bus.rmw ? p2_latch_r : pin_sync.p2;
  wire [7:0] p3_rd = bus.rmw ? p3_latch_r : pin_sync.p3;
  wire [7:0] p4_rd = bus.rmw ? p4_latch_r : pin_sync.p4;
  wire [7:0] p6_rd = bus.rmw ? p6_latch_r : pin_sync.p6;

  // Read data selection; unused upper bits and unmapped addresses give zero.
  logic [7:0] rd_sel;
  always_comb begin
    rd_sel = lip_pkg::RD_NONE;
    case (bus.addr)
      lip_pkg::ADDR_P1_LATCH: rd_sel = {2'h0, p1_rd};
      lip_pkg::ADDR_P2_LATCH: rd_sel = {5'h00, p2_rd};
      lip_pkg::ADDR_P3_LATCH: rd_sel = p3_rd;
      lip_pkg::ADDR_P4_LATCH: rd_sel = p4_rd;
      lip_pkg::ADDR_P6_LATCH: rd_sel = p6_rd;
      lip_pkg::ADDR_P1_DIR:   rd_sel = {2'h0, p1_dir_r};
      lip_pkg::ADDR_P3_DIR:   rd_sel = p3_dir_r;
      lip_pkg::ADDR_P4_DIR:   rd_sel = p4_dir_r;
      lip_pkg::ADDR_P6_DIR:   rd_sel = p6_dir_r;
      lip_pkg::ADDR_P3_ODE:   rd_sel = p3_ode_r;
      lip_pkg::ADDR_P4_ODE:   rd_sel = p4_ode_r;
      default:                rd_sel = lip_pkg::RD_NONE;
    endcase
  end

  // Pins are captured only in S1 of a read; the value then stands until the
  // next read so the processor may pick it up later in the cycle.
  wire       rd_s1         = bus.rd & bus.s1;
  wire [7:0] bus_rdata_nxt = rd_s1 ? rd_sel : bus_rdata;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= lip_pkg::RD_NONE;
    end else begin
      bus_rdata <= bus_rdata_nxt;
    end
  end

  // Flat per-pin views of latch, direction and open-drain selection.
  // Port 2 has no direction register and behaves as open drain, so a latch
  // of one releases the pin; the first and sixth ports are push-pull only.
  lip_pkg::lip_pins_t latch_all;
  lip_pkg::lip_pins_t dir_all;
  lip_pkg::lip_pins_t ode_all;
  logic [32:0]        latch_flat;
  logic [32:0]        dir_flat;
  logic [32:0]        ode_flat;
  logic [32:0]        out_nxt;
  logic [32:0]        oe_nxt;

  assign latch_all  = '{p6: p6_latch_nxt, p4: p4_latch_nxt, p3: p3_latch_nxt,
                        p2: p2_latch_nxt, p1: p1_latch_nxt};
  assign dir_all    = '{p6: p6_dir_nxt, p4: p4_dir_nxt, p3: p3_dir_nxt,
                        p2: lip_pkg::P2_DIR_FIXED, p1: p1_dir_nxt};
  assign ode_all    = '{p6: lip_pkg::P6_ODE_FIXED, p4: p4_ode_nxt, p3: p3_ode_nxt,
                        p2: lip_pkg::P2_ODE_FIXED, p1: lip_pkg::P1_ODE_FIXED};
  assign latch_flat = latch_all;
  assign dir_flat   = dir_all;
  assign ode_flat   = ode_all;

  // Per-pin driver: enabled only in output mode, and in open-drain mode only
  // while pulling low. Pins are registered from the next values so a latch
  // write reaches the pin on the same edge that loads the latch.
  genvar gi;
  generate
    for (gi = 0; gi < lip_pkg::PIN_W; gi++) begin : g_pin
      assign out_nxt[gi] = latch_flat[gi];
      assign oe_nxt[gi]  = dir_flat[gi] & ~(ode_flat[gi] & latch_flat[gi]);
    end
  endgenerate

  // Pin levels; taken from the next latch values, so a write shows on the pin
  // at the edge that loads the latch, with no extra cycle of lag.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
    end else begin
      pin_out <= out_nxt;
    end
  end

  // Pin driver enables; all off from reset, so no pin drives before software
  // has chosen output mode for it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= oe_nxt;
    end
  end

endmodule

// ### shared/lip_pkg.sv
// Shared constants and types of the latched I/O port group.
// Assumes a processor bus with 16-bit byte addresses and 8-bit data.
package lip_pkg;

  // Port widths.
  localparam int unsigned P1_W   = 6;
  localparam int unsigned P2_W   = 3;
  localparam int unsigned P3_W   = 8;
  localparam int unsigned P4_W   = 8;
  localparam int unsigned P6_W   = 8;
  localparam int unsigned PIN_W  = 33;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 16;

  // Output latch and first port direction addresses in the special function register space.
  localparam logic [15:0] ADDR_P1_LATCH = 16'h0001;
  localparam logic [15:0] ADDR_P2_LATCH = 16'h0002;
  localparam logic [15:0] ADDR_P3_LATCH = 16'h0003;
  localparam logic [15:0] ADDR_P4_LATCH = 16'h0004;
  localparam logic [15:0] ADDR_P6_LATCH = 16'h0006;
  localparam logic [15:0] ADDR_P1_DIR   = 16'h000B;

  // Control registers in the data buffer register space.
  localparam logic [15:0] ADDR_P3_ODE   = 16'h1F83;
  localparam logic [15:0] ADDR_P4_ODE   = 16'h1F84;
  localparam logic [15:0] ADDR_P3_DIR   = 16'h1F89;
  localparam logic [15:0] ADDR_P4_DIR   = 16'h1F8A;
  localparam logic [15:0] ADDR_P6_DIR   = 16'h1F8C;

  // Reset values.
  localparam logic [7:0] RST_LATCH    = 8'h00;
  localparam logic [2:0] RST_P2_LATCH = 3'h7;
  localparam logic [7:0] RST_DIR      = 8'h00;
  localparam logic [7:0] RST_ODE      = 8'h00;
  localparam logic [7:0] RD_NONE      = 8'h00;

  // Fixed per-pin modes of ports without the matching control register.
  localparam logic [2:0] P2_DIR_FIXED = 3'h7;
  localparam logic [2:0] P2_ODE_FIXED = 3'h7;
  localparam logic [5:0] P1_ODE_FIXED = 6'h00;
  localparam logic [7:0] P6_ODE_FIXED = 8'h00;

  // One bit per pin of every port, first port in the low bits.
  typedef struct packed {
    logic [7:0] p6;
    logic [7:0] p4;
    logic [7:0] p3;
    logic [2:0] p2;
    logic [5:0] p1;
  } lip_pins_t;

  // Processor access to the port group.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        rmw;
    logic        s1;
    logic        s2;
  } lip_bus_t;

endpackage

// ### verilog/lip_sync.sv
// Two-stage synchroniser for the raw pin levels.
// Assumes asynchronous pins; only the second stage may be read.
`timescale 1ns/1ns
module lip_sync #(
  parameter int unsigned W = 33
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // The first stage feeds only the second, keeping metastability contained.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ### tb/lip_asserts.sv
// Port-level assertions for the latched port group.
// Assumes one clock and pins held steady for four edges before a pin read.
`timescale 1ns/1ns
module lip_asserts (
  input wire logic               clk_sys,
  input wire logic               rst,
  input wire lip_pkg::lip_bus_t  bus,
  input wire logic [7:0]         bus_rdata,
  input wire lip_pkg::lip_pins_t pin_in,
  input wire lip_pkg::lip_pins_t pin_out,
  input wire lip_pkg::lip_pins_t pin_oe
);
  // Writes land only in S2 and reads sample only in S1.
  wire logic wr_any  = bus.wr && bus.s2;
  wire logic rd_any  = bus.rd && bus.s1;
  wire logic p1_hit  = bus.addr == lip_pkg::ADDR_P1_LATCH;
  wire logic dir_hit = bus.addr == lip_pkg::ADDR_P1_DIR;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_latch_load: assert property (wr_any && p1_hit |=> pin_out.p1 == $past(bus.wdata[5:0]))
    else $error("latch write not on pins");
  a_latch_hold: assert property (!$past(rst) && !wr_any |=> $stable(pin_out))
    else $error("pin levels moved without write");
  a_dir_load: assert property (wr_any && dir_hit |=> pin_oe.p1 == $past(bus.wdata[5:0]))
    else $error("direction write not on enables");
  a_oe_hold: assert property (!$past(rst) && !wr_any |=> $stable(pin_oe))
    else $error("enables moved without write");
  a_input_keep: assert property (wr_any && p1_hit && pin_oe.p1 == 6'h00 |=> pin_oe.p1 == 6'h00)
    else $error("latch write enabled an input pin");
  a_rmw_read: assert property (rd_any && bus.rmw && p1_hit |=> bus_rdata == {2'h0, $past(pin_out.p1)})
    else $error("rmw read not latch");
  a_pin_read: assert property (rd_any && !bus.rmw && p1_hit |=> bus_rdata == {2'h0, $past(pin_in.p1, 3)})
    else $error("plain read not pin level");
  a_rdata_hold: assert property (!rd_any |=> $stable(bus_rdata))
    else $error("read data moved outside S1");
  // Checked from the second edge in reset; at the first one after power-up the flops may not be set yet.
  a_reset_clear: assert property (disable iff (1'b0) rst ##1 rst |-> pin_oe == '0 && pin_out.p1 == 6'h00)
    else $error("reset did not clear port");
  a_drain_only: assert property (!$past(rst) |-> pin_oe.p2 == ~pin_out.p2)
    else $error("second port not open drain");
endmodule

// ### tb/lip_pin_model.sv
// Outside circuit on the pins: resolves each pin from both drivers.
// Assumes released pins show the outside level, pull-ups included.
`timescale 1ns/1ns
module lip_pin_model (
  input wire lip_pkg::lip_pins_t ext,
  input wire lip_pkg::lip_pins_t pin_out,
  input wire lip_pkg::lip_pins_t pin_oe,
  output lip_pkg::lip_pins_t     pin_lvl
);
  // An enabled port driver wins; an outside short is never modelled.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

// ### tb/latched_io_port_group_bench.sv
// Self-checking bench for the latched port group.
// Assumes the pin model and checker are compiled alongside.
`timescale 1ns/1ns
module latched_io_port_group_bench;
  logic               clk_sys;
  logic               rst;
  lip_pkg::lip_bus_t  bus;
  logic [7:0]         bus_rdata;
  lip_pkg::lip_pins_t pin_in;
  lip_pkg::lip_pins_t pin_out;
  lip_pkg::lip_pins_t pin_oe;
  lip_pkg::lip_pins_t ext;
  int                 n_fail;
  int                 checked;
  logic [7:0]         rv;
  logic [7:0]         d;
  logic [7:0]         m;
  logic [15:0]        lat [3];
  logic [15:0]        dir [3];

  lip_port_group lip_port_group_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus), .bus_rdata(bus_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  lip_pin_model lip_pin_model_inst (.ext(ext), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_in));

  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Expected pin read: outputs show the latch, inputs the outside level.
  function automatic logic [7:0] exp_pin(input logic [7:0] l, input logic [7:0] r, input logic [7:0] x);
    return ((l & r) | (x & ~r)) & 8'h3F;
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each access holds for one edge, then a quiet cycle follows.
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    bus = {a, v, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    @(negedge clk_sys);
    bus = '0;
    @(negedge clk_sys);
  endtask

  task automatic rd(input logic [15:0] a, input logic r);
    bus = {a, 8'h00, 1'b0, 1'b1, r, 1'b1, 1'b0};
    @(negedge clk_sys);
    bus = '0;
    rv = bus_rdata;
    @(negedge clk_sys);
  endtask

  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    bus = '0;
    ext = '0;
    rst = 1'b1;
    lat = '{lip_pkg::ADDR_P3_LATCH, lip_pkg::ADDR_P4_LATCH, lip_pkg::ADDR_P6_LATCH};
    dir = '{lip_pkg::ADDR_P3_DIR, lip_pkg::ADDR_P4_DIR, lip_pkg::ADDR_P6_DIR};
    void'($urandom(64));
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("oe", 8'h00, {2'h0, pin_oe.p1});
    rd(lip_pkg::ADDR_P1_DIR, 1'b0);
    chk("dir", 8'h00, rv);
    rd(lip_pkg::ADDR_P1_LATCH, 1'b1);
    chk("latch", 8'h00, rv);
    // An address of another block on this bus; the reserved range stays untouched.
    rd(16'h0010, 1'b0);
    chk("unmapped", 8'h00, rv);
    // Random latch and direction mixes; all inputs and all outputs first.
    for (int i = 0; i < 12; i++) begin
      d = 8'($urandom);
      m = (i < 2) ? {8{i[0]}} : 8'($urandom);
      ext.p1 = 6'($urandom);
      wr(lip_pkg::ADDR_P1_DIR, m);
      wr(lip_pkg::ADDR_P1_LATCH, d);
      chk("oe", {2'h0, m[5:0]}, {2'h0, pin_oe.p1});
      repeat (2) @(negedge clk_sys);
      rd(lip_pkg::ADDR_P1_LATCH, 1'b0);
      chk("pin", exp_pin(d, m, {2'h0, ext.p1}), rv);
      rd(lip_pkg::ADDR_P1_LATCH, 1'b1);
      chk("rmw", d & 8'h3F, rv);
    end
    // A write without S2 and a read without S1 are refused and change nothing.
    bus = {lip_pkg::ADDR_P1_LATCH, ~d, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    @(negedge clk_sys);
    bus = {lip_pkg::ADDR_P1_DIR, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    @(negedge clk_sys);
    bus = '0;
    chk("no s1", d & 8'h3F, bus_rdata);
    rd(lip_pkg::ADDR_P1_LATCH, 1'b1);
    chk("no s2", d & 8'h3F, rv);
    // Remaining eight-bit ports driven as outputs and read back at the pins.
    for (int k = 0; k < 3; k++) begin
      d = 8'($urandom);
      wr(dir[k], 8'hFF);
      wr(lat[k], d);
      repeat (2) @(negedge clk_sys);
      rd(lat[k], 1'b0);
      chk("port", d, rv);
      rd(dir[k], 1'b0);
      chk("dir", 8'hFF, rv);
      rd(lat[k], 1'b1);
      chk("port rmw", d, rv);
    end
    // Second port is open drain: a latch one releases the pin to the outside level.
    ext.p2 = 3'h7;
    wr(lip_pkg::ADDR_P2_LATCH, 8'h05);
    chk("p2 oe", 8'h02, {5'h00, pin_oe.p2});
    rd(lip_pkg::ADDR_P2_LATCH, 1'b1);
    chk("p2 rmw", 8'h05, rv);
    rd(lip_pkg::ADDR_P2_LATCH, 1'b0);
    chk("p2 pin", 8'h05, rv);
    // Open drain on the whole third port and the upper half of the fourth; open-drain bits with a latch one follow the outside.
    ext.p3 = 8'($urandom);
    ext.p4 = 8'($urandom);
    d = 8'($urandom);
    wr(lip_pkg::ADDR_P3_ODE, 8'hFF);
    wr(lip_pkg::ADDR_P4_ODE, 8'hF0);
    wr(lip_pkg::ADDR_P3_LATCH, d);
    wr(lip_pkg::ADDR_P4_LATCH, d);
    rd(lip_pkg::ADDR_P3_LATCH, 1'b0);
    chk("p3 drain", d & ext.p3, rv);
    rd(lip_pkg::ADDR_P4_LATCH, 1'b0);
    chk("p4 drain", d & (ext.p4 | 8'h0F), rv);
    rd(lip_pkg::ADDR_P3_ODE, 1'b0);
    chk("p3 ode", 8'hFF, rv);
    rd(lip_pkg::ADDR_P4_ODE, 1'b0);
    chk("p4 ode", 8'hF0, rv);
    rd(lip_pkg::ADDR_P4_LATCH, 1'b1);
    chk("p4 rmw", d, rv);
    // Reset in mid-run, with the first port driving, clears it again.
    wr(lip_pkg::ADDR_P1_DIR, 8'h3F);
    wr(lip_pkg::ADDR_P1_LATCH, 8'h2A);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("rst oe", 8'h00, {2'h0, pin_oe.p1});
    rd(lip_pkg::ADDR_P1_LATCH, 1'b1);
    chk("rst latch", 8'h00, rv);
    rd(lip_pkg::ADDR_P1_DIR, 1'b0);
    chk("rst dir", 8'h00, rv);
    summarize();
  end
endmodule

bind lip_port_group lip_asserts lip_asserts_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
  .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
